// ==== hw/fpiu_pkg.sv ====
// fpiu_pkg: constants, register map and carrier types of the interrupt unit
// assumes: shared by the interrupt unit top, its property checks and its bench
package fpiu_pkg;
  localparam int NSRC = 4;
  // ahb-lite map, one aligned word per register
  localparam logic [7:0] OPT_ADDR = 8'hC8;        // option register, write only
  localparam logic [7:0] STAT_ADDR = 8'hCC;       // status readback
  localparam logic [7:0] EVT_ADDR = 8'hD0;        // per-event flags, write one to clear
  localparam logic [7:0] OPT_RESET = 8'h00;
  localparam int LES_BIT = 6;
  localparam int ESB_BIT = 5;
  localparam int GEN_BIT = 4;
  localparam int NEVT = 8;                        // events folded onto the sources
  // vector addresses
  localparam logic [11:0] VEC_NMI = 12'hFFC;
  localparam logic [11:0] VEC_S1 = 12'hFF6;
  localparam logic [11:0] VEC_S2 = 12'hFF4;
  localparam logic [11:0] VEC_S3 = 12'hFF2;
  localparam logic [11:0] VEC_S4 = 12'hFF0;
  localparam int DEFECT_CYCLES = 3;               // leading cycles of the clearing load
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // active mode / flag pair in use
  typedef enum logic [1:0] {
    FPIU_NORMAL = 2'h0,
    FPIU_SERVICE = 2'h1,
    FPIU_NMI = 2'h3
  } fpiu_mode_t;

  // carry and zero pair
  typedef struct packed {
    logic carry;
    logic zero;
  } fpiu_flags_t;

  // dispatch towards the core
  typedef struct packed {
    logic take;
    logic [11:0] vector;
    logic [2:0] source;   // 0 non-maskable, 1..4 maskable
  } fpiu_disp_t;
endpackage

// ==== hw/fpiu_edge_latch.sv ====
// fpiu_edge_latch: stores one edge request until its routine starts
// assumes: input already synchronised to i_mclk
`timescale 1ns/1ps
module fpiu_edge_latch (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // request line and control
  input wire logic i_line,
  input wire logic i_rising,
  input wire logic i_clear,
  // stored request
  output logic o_pending
);
  logic prev_r, prev_nxt, pend_r, pend_nxt, edge_hit;
  logic armed_r, armed_nxt;

  // edge detect, set wins over the clear; the first cycle after reset only
  // loads the line's level, so a reset value that differs from it is no edge
  always_comb begin
    prev_nxt = i_line;
    armed_nxt = 1'b1;
    edge_hit = armed_r & (i_rising ? (i_line & ~prev_r) : (~i_line & prev_r));
    pend_nxt = edge_hit | (pend_r & ~i_clear);
  end

  // registers
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      prev_r <= 1'b1;
      pend_r <= 1'b0;
      armed_r <= 1'b0;
    end else begin
      armed_r <= armed_nxt;
      prev_r <= prev_nxt;
      pend_r <= pend_nxt;
    end
  end

  assign o_pending = pend_r;
endmodule

// ==== hw/fpiu_top.sv ====
// fpiu_top: fixed priority interrupt unit with ahb-lite option registers
// assumes: core strobes instruction ends, return and the clearing load on i_mclk
//
// Our own choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
module fpiu_top (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // ahb-lite slave
  input wire logic i_hsel,
  input wire logic [7:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic i_hready,
  input wire logic [31:0] i_hwdata,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  // request pins, asynchronous; nmi and source one active low, source two polarity selectable
  input wire logic i_nmi_n,
  input wire logic i_src1_n,
  input wire logic i_src2,
  // on-chip events, same clock, or'ed onto sources
  input wire logic [fpiu_pkg::NEVT-1:0] i_evt,
  input wire logic [fpiu_pkg::NEVT*2-1:0] i_evt_route,
  // core handshake
  input wire logic i_instr_end,
  input wire logic i_ret,
  input wire logic i_clr_load,
  input wire logic i_asleep,
  input wire logic [11:0] i_pc,
  input wire logic i_flags_we,
  input wire fpiu_pkg::fpiu_flags_t i_flags_wr,
  // towards the core
  output fpiu_pkg::fpiu_disp_t o_disp,
  output logic [11:0] o_pc_pop,
  output fpiu_pkg::fpiu_flags_t o_flags,
  output fpiu_pkg::fpiu_mode_t o_mode,
  output logic o_wake
);
  import fpiu_pkg::*;

  // two-flop synchronisers for the pins
  logic [2:0] sync1_r, sync2_r;
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      sync1_r <= 3'h3; // source two idles low, the others high
      sync2_r <= 3'h3;
    end else begin
      sync1_r <= {i_src2, i_src1_n, i_nmi_n};
      sync2_r <= sync1_r;
    end
  end

  // bus state and option register
  logic [7:0] opt_r, opt_nxt;
  logic wr_pend_r, wr_pend_nxt;
  logic [7:0] wr_addr_r, wr_addr_nxt, rd_addr_r, rd_addr_nxt;
  logic rd_pend_r, rd_pend_nxt;
  logic [NEVT-1:0] evt_flag_r, evt_flag_nxt, evt_clr;
  logic global_irq_enable, src1_level_select, src2_polarity_select;
  logic addr_ok;

  assign global_irq_enable = opt_r[GEN_BIT];
  assign src1_level_select = opt_r[LES_BIT];
  assign src2_polarity_select = opt_r[ESB_BIT];

  // address phase capture and option write
  always_comb begin
    addr_ok = i_hsel & i_hready & (i_htrans == HTRANS_NONSEQ) & (i_hsize == HSIZE_WORD);
    wr_pend_nxt = addr_ok & i_hwrite;
    rd_pend_nxt = addr_ok & ~i_hwrite;
    wr_addr_nxt = addr_ok ? i_haddr : wr_addr_r;
    rd_addr_nxt = addr_ok ? i_haddr : rd_addr_r;
    opt_nxt = opt_r;
    evt_clr = '0;
    if (wr_pend_r && wr_addr_r == OPT_ADDR)
      opt_nxt = i_hwdata[7:0];
    if (wr_pend_r && wr_addr_r == EVT_ADDR)
      evt_clr = i_hwdata[NEVT-1:0];
    evt_flag_nxt = i_evt | (evt_flag_r & ~evt_clr);
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      opt_r <= OPT_RESET;
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      rd_addr_r <= 8'h00;
      evt_flag_r <= '0;
    end else begin
      opt_r <= opt_nxt;
      wr_pend_r <= wr_pend_nxt;
      rd_pend_r <= rd_pend_nxt;
      wr_addr_r <= wr_addr_nxt;
      rd_addr_r <= rd_addr_nxt;
      evt_flag_r <= evt_flag_nxt;
    end
  end

  // read data registered for the next data phase; option reads as zero
  logic [31:0] hrdata_r, hrdata_nxt;
  fpiu_mode_t mode_r, mode_nxt;
  logic [NSRC:0] req;
  always_comb begin
    hrdata_nxt = 32'h0000_0000;
    if (addr_ok && !i_hwrite && i_haddr == STAT_ADDR)
      hrdata_nxt = {24'h00_0000, 1'b0, req[NSRC:1], req[0], mode_r};
    else if (addr_ok && !i_hwrite && i_haddr == EVT_ADDR)
      hrdata_nxt = {{(32-NEVT){1'b0}}, evt_flag_nxt};
  end
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst)
      hrdata_r <= 32'h0000_0000;
    else
      hrdata_r <= hrdata_nxt;
  end
  assign o_hrdata = hrdata_r;
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;

  // events or'ed onto sources by route code
  logic [NSRC-1:0] evt_src;
  always_comb begin
    evt_src = '0;
    for (int k = 0; k < NEVT; k++)
      evt_src[i_evt_route[k*2 +: 2]] = evt_src[i_evt_route[k*2 +: 2]] | i_evt[k];
  end

  // entry strobes per source
  logic take_now;
  logic [2:0] win;
  logic nmi_r, nmi_nxt;
  logic s1_edge, s2_edge;

  // source one falling edge latch
  fpiu_edge_latch u_s1 (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_line(sync2_r[1] & ~evt_src[0]),
    .i_rising(1'b0),
    .i_clear(take_now && win == 3'd1),
    .o_pending(s1_edge)
  );

  // source two selectable edge latch
  fpiu_edge_latch u_s2 (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_line(sync2_r[2] | evt_src[1]),
    .i_rising(src2_polarity_select),
    .i_clear(take_now && win == 3'd2),
    .o_pending(s2_edge)
  );

  // request vector and nmi capture
  logic nmi_prev_r;
  always_comb begin
    nmi_nxt = (nmi_prev_r & ~sync2_r[0]) | (nmi_r & ~(take_now && win == 3'd0));
    req[0] = nmi_r;
    req[1] = src1_level_select ? (~sync2_r[1] | evt_src[0]) : s1_edge;
    req[2] = s2_edge;
    req[3] = evt_src[2];
    req[4] = evt_src[3];
  end
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      nmi_r <= 1'b0;
      nmi_prev_r <= 1'b1;
    end else begin
      nmi_r <= nmi_nxt;
      nmi_prev_r <= sync2_r[0];
    end
  end

  // arbitration and dispatch at instruction end
  fpiu_mode_t prev_mode_r, prev_mode_nxt;
  logic [11:0] stack_r, stack_nxt, nstack_r, nstack_nxt;
  logic mask_ok, swap_skip;
  logic [11:0] vec;
  logic [1:0] defect_cnt_r, defect_cnt_nxt;
  always_comb begin
    mask_ok = global_irq_enable && mode_r == FPIU_NORMAL;
    win = 3'd7;
    vec = VEC_S4;
    if (req[0] && mode_r != FPIU_NMI) begin
      win = 3'd0;
      vec = VEC_NMI;
    end else if (mask_ok && req[1]) begin
      win = 3'd1;
      vec = VEC_S1;
    end else if (mask_ok && req[2]) begin
      win = 3'd2;
      vec = VEC_S2;
    end else if (mask_ok && req[3]) begin
      win = 3'd3;
      vec = VEC_S3;
    end else if (mask_ok && req[4]) begin
      win = 3'd4;
      vec = VEC_S4;
    end
    take_now = i_instr_end && win != 3'd7;
    // clearing load counts its leading cycles
    defect_cnt_nxt = i_clr_load ? ((defect_cnt_r == 2'(DEFECT_CYCLES)) ? defect_cnt_r
                                   : defect_cnt_r + 2'd1) : 2'd0;
    swap_skip = i_clr_load && defect_cnt_r < 2'(DEFECT_CYCLES) && win != 3'd0;
    mode_nxt = mode_r;
    prev_mode_nxt = prev_mode_r;
    stack_nxt = stack_r;
    nstack_nxt = nstack_r;
    if (take_now) begin
      // entry: mode swap, push pc, inhibit, latch cleared above, vector out
      if (win == 3'd0) begin
        mode_nxt = FPIU_NMI;
        prev_mode_nxt = mode_r;
        nstack_nxt = i_pc;
      end else begin
        mode_nxt = FPIU_SERVICE;
        stack_nxt = i_pc;
      end
    end else if (i_ret && mode_r != FPIU_NORMAL) begin
      mode_nxt = (mode_r == FPIU_NMI) ? prev_mode_r : FPIU_NORMAL;
    end
  end

  // flag pairs, one per mode
  fpiu_flags_t pair_r [3];
  fpiu_flags_t pair_nxt [3];
  fpiu_flags_t flags_r; // active pair, registered for the output
  logic [1:0] sel_r, sel_nxt;
  logic [1:0] psel_r, psel_nxt;
  always_comb begin
    pair_nxt = pair_r;
    if (i_flags_we)
      pair_nxt[sel_r] = i_flags_wr;
    sel_nxt = sel_r;
    psel_nxt = psel_r;
    if (take_now) begin
      if (win == 3'd0) begin
        sel_nxt = 2'd2;
        psel_nxt = sel_r;
      end else if (!swap_skip) begin
        sel_nxt = 2'd1;
      end
    end else if (i_ret && mode_r == FPIU_NMI) begin
      sel_nxt = psel_r;
    end else if (i_ret && mode_r == FPIU_SERVICE) begin
      sel_nxt = 2'd0;
    end
  end

  // dispatch and pop outputs
  fpiu_disp_t disp_r, disp_nxt;
  logic [11:0] pop_r, pop_nxt;
  logic wake_r, wake_nxt;
  always_comb begin
    disp_nxt.take = take_now;
    disp_nxt.vector = take_now ? vec : disp_r.vector;
    disp_nxt.source = take_now ? win : disp_r.source;
    pop_nxt = pop_r;
    if (i_ret && mode_r == FPIU_NMI)
      pop_nxt = nstack_r;
    else if (i_ret && mode_r == FPIU_SERVICE)
      pop_nxt = stack_r;
    wake_nxt = i_asleep && global_irq_enable && (|req);
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      mode_r <= FPIU_NORMAL;
      prev_mode_r <= FPIU_NORMAL;
      stack_r <= 12'h000;
      nstack_r <= 12'h000;
      defect_cnt_r <= 2'd0;
      pair_r <= '{default: '0};
      flags_r <= '0;
      sel_r <= 2'd0;
      psel_r <= 2'd0;
      disp_r <= '0;
      pop_r <= 12'h000;
      wake_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      prev_mode_r <= prev_mode_nxt;
      stack_r <= stack_nxt;
      nstack_r <= nstack_nxt;
      defect_cnt_r <= defect_cnt_nxt;
      pair_r <= pair_nxt;
      flags_r <= pair_nxt[sel_nxt];
      sel_r <= sel_nxt;
      psel_r <= psel_nxt;
      disp_r <= disp_nxt;
      pop_r <= pop_nxt;
      wake_r <= wake_nxt;
    end
  end

  assign o_disp = disp_r;
  assign o_pc_pop = pop_r;
  assign o_flags = flags_r;
  assign o_mode = mode_r;
  assign o_wake = wake_r;
endmodule

// ==== verif/fpiu_core_model.sv ====
// fpiu_core_model: core stand-in that strobes instruction ends and returns
// assumes: bench commands are one-cycle pulses on i_mclk
`timescale 1ns/1ps
module fpiu_core_model (
  // clock, reset, commands
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_go,
  input wire logic i_back,
  // towards the unit
  output logic o_instr_end,
  output logic o_ret,
  output logic [11:0] o_pc
);
  // one strobe per command, pc steps once per instruction
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_instr_end <= 1'b0;
      o_ret <= 1'b0;
      o_pc <= 12'h100;
    end else begin
      o_instr_end <= i_go;
      o_ret <= i_back;
      if (i_go) begin
        o_pc <= o_pc + 12'h001;
      end
    end
  end
endmodule

// ==== verif/fpiu_top_props.sv ====
// fpiu_top_props: port timing checks of the interrupt unit
// assumes: bound to fpiu_top, one clock, async active-high reset
`timescale 1ns/1ps
module fpiu_top_props
  import fpiu_pkg::*;
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // bus and core inputs
  input wire logic i_hsel,
  input wire logic [7:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic i_hready,
  input wire logic i_instr_end,
  input wire logic i_ret,
  input wire logic i_asleep,
  // observed outputs
  input wire logic [31:0] o_hrdata,
  input wire fpiu_pkg::fpiu_disp_t o_disp,
  input wire fpiu_pkg::fpiu_mode_t o_mode,
  input wire logic o_wake
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // dispatch follows a sampled instruction end
  a_take_at_end: assert property (o_disp.take |-> $past(i_instr_end))
    else $error("take without instruction end");
  a_vector_map: assert property (o_disp.take |-> o_disp.vector ==
    (o_disp.source == 3'h0 ? VEC_NMI : o_disp.source == 3'h1 ? VEC_S1 :
    o_disp.source == 3'h2 ? VEC_S2 : o_disp.source == 3'h3 ? VEC_S3 : VEC_S4))
    else $error("vector does not match source");
  a_no_nesting: assert property (o_disp.take && o_disp.source != 3'h0 |->
    $past(o_mode) == FPIU_NORMAL) else $error("maskable taken outside normal mode");
  a_nmi_entry: assert property (o_disp.take && o_disp.source == 3'h0 |->
    o_mode == FPIU_NMI) else $error("nmi entry without nmi mode");
  a_svc_entry: assert property (o_disp.take && o_disp.source != 3'h0 |->
    o_mode == FPIU_SERVICE) else $error("maskable entry without service mode");
  a_wake_gate: assert property (o_wake |-> $past(i_asleep))
    else $error("wake while awake");
  a_ret_normal: assert property (i_ret && !i_instr_end && o_mode == FPIU_SERVICE
    |=> o_mode == FPIU_NORMAL) else $error("return did not restore normal");
  a_opt_hidden: assert property (i_hsel && i_hready && i_htrans == HTRANS_NONSEQ
    && !i_hwrite && i_haddr == OPT_ADDR |=> o_hrdata == 32'h0)
    else $error("option register readable");
  a_mode_legal: assert property (o_mode != 2'h2)
    else $error("illegal mode");
endmodule
bind fpiu_top fpiu_top_props i_fpiu_top_props (.i_mclk, .i_rst, .i_hsel, .i_haddr,
  .i_htrans, .i_hwrite, .i_hready, .i_instr_end, .i_ret, .i_asleep, .o_hrdata,
  .o_disp, .o_mode, .o_wake);

// ==== verif/fpiu_top_bench.sv ====
// fpiu_top_bench: directed scenarios for the interrupt unit
// assumes: core model strobes instruction ends, bench is the bus master
`timescale 1ns/1ps
`define CHK(nm, e, s) begin samples_checked++; if ((e) !== (s)) begin err_total++; \
  $display("[FAIL] %s exp %0h got %0h", nm, e, s); end end
module fpiu_top_bench;
  import fpiu_pkg::*;
  logic i_mclk, i_rst, hsel, hwrite, nmi_n, src1_n, src2, go, back, asleep;
  logic instr_end, ret, hrdy, hresp, wake;
  logic clr_load, flags_we;
  fpiu_flags_t flags_wr;
  logic [7:0] haddr, evt;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic [11:0] pc, pc_pop, exp_pc;
  fpiu_disp_t disp;
  fpiu_flags_t flags;
  fpiu_mode_t mode;
  int err_total, samples_checked;
  // unit and its core
  fpiu_top i_fpiu_top (.i_mclk(i_mclk), .i_rst(i_rst), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hready(hrdy),
    .i_hwdata(hwdata), .o_hrdata(hrdata), .o_hreadyout(hrdy), .o_hresp(hresp),
    .i_nmi_n(nmi_n), .i_src1_n(src1_n), .i_src2(src2), .i_evt(evt),
    .i_evt_route(16'h000E), .i_instr_end(instr_end), .i_ret(ret), .i_clr_load(clr_load),
    .i_asleep(asleep), .i_pc(pc), .i_flags_we(flags_we), .i_flags_wr(flags_wr),
    .o_disp(disp), .o_pc_pop(pc_pop), .o_flags(flags), .o_mode(mode), .o_wake(wake));
  fpiu_core_model i_fpiu_core_model (.i_mclk(i_mclk), .i_rst(i_rst), .i_go(go),
    .i_back(back), .o_instr_end(instr_end), .o_ret(ret), .o_pc(pc));
  // verdict and end of run
  task automatic report_and_stop;
    if (err_total == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // next edge with hready high, bounded
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge i_mclk);
    while (hrdy !== 1'b1) begin
      n++;
      if (n > 16) begin
        err_total++;
        report_and_stop;
      end
      @(posedge i_mclk);
    end
  endtask
  // one ahb-lite single word transfer
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    haddr <= a;
    hsize <= HSIZE_WORD;
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    rd = hrdata;
  endtask
  // pin synchroniser settling
  task automatic settle;
    repeat (4) @(posedge i_mclk);
  endtask
  // end an instruction and judge the dispatch
  task automatic issue(input logic tk, input logic [2:0] src, input logic [11:0] vec);
    go <= 1'b1;
    @(posedge i_mclk);
    go <= 1'b0;
    @(posedge i_mclk);
    #1;
    `CHK("take", tk, disp.take)
    if (tk) begin
      exp_pc = pc;
      `CHK("source", src, disp.source)
      `CHK("vector", vec, disp.vector)
    end
    @(posedge i_mclk);
  endtask
  // return from a routine and judge the restored state
  task automatic leave(input fpiu_mode_t m, input logic chk_pc);
    back <= 1'b1;
    @(posedge i_mclk);
    back <= 1'b0;
    repeat (2) @(posedge i_mclk);
    #1;
    `CHK("mode", m, mode)
    if (chk_pc) begin
      `CHK("pc_pop", exp_pc, pc_pop)
    end
    @(posedge i_mclk);
  endtask
  // reset values, write-only option, unmapped read
  task automatic t_reset;
    bus(1'b0, OPT_ADDR, 32'h0);
    `CHK("opt_read", 32'h0, rd)
    bus(1'b0, 8'h40, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    `CHK("mode0", FPIU_NORMAL, mode)
    `CHK("hresp", 1'b0, hresp)
  endtask
  // write the active flag pair, then let it settle
  task automatic set_flags(input fpiu_flags_t v);
    flags_we <= 1'b1;
    flags_wr <= v;
    @(posedge i_mclk);
    flags_we <= 1'b0;
    @(posedge i_mclk);
  endtask
  // flag pair per mode, restore on return, swap skipped early in the clearing load
  task automatic t_flags;
    set_flags(2'h3);
    `CHK("flags_n", 2'h3, flags)
    evt <= 8'h01;
    issue(1'b1, 3'h3, VEC_S3);
    `CHK("flags_i", 2'h0, flags)
    set_flags(2'h1);
    `CHK("flags_iw", 2'h1, flags)
    evt <= 8'h00;
    leave(FPIU_NORMAL, 1'b1);
    `CHK("flags_r", 2'h3, flags)
    clr_load <= 1'b1;
    evt <= 8'h01;
    issue(1'b1, 3'h3, VEC_S3);
    `CHK("mode_d", FPIU_SERVICE, mode)
    `CHK("flags_d", 2'h3, flags)
    clr_load <= 1'b0;
    evt <= 8'h00;
    leave(FPIU_NORMAL, 1'b1);
    clr_load <= 1'b1;
    repeat (3) @(posedge i_mclk);
    evt <= 8'h01;
    issue(1'b1, 3'h3, VEC_S3);
    `CHK("flags_l", 2'h1, flags)
    clr_load <= 1'b0;
    evt <= 8'h00;
    leave(FPIU_NORMAL, 1'b1);
    `CHK("flags_e", 2'h3, flags)
  endtask
  // global enable low: maskables blocked, nmi served but no wake
  task automatic t_gen_off;
    bus(1'b1, OPT_ADDR, 32'h0);
    evt <= 8'h01;
    settle;
    issue(1'b0, 3'h0, 12'h0);
    nmi_n <= 1'b0;
    asleep <= 1'b1;
    settle;
    `CHK("wake", 1'b0, wake)
    asleep <= 1'b0;
    issue(1'b1, 3'h0, VEC_NMI);
    nmi_n <= 1'b1;
    evt <= 8'h00;
    bus(1'b1, EVT_ADDR, 32'hFF);
    leave(FPIU_NORMAL, 1'b0);
    issue(1'b0, 3'h0, 12'h0);
  endtask
  // priority order, no nesting, re-dispatch after return
  task automatic t_priority;
    bus(1'b1, OPT_ADDR, 32'h50);
    evt <= 8'h03;
    src1_n <= 1'b0;
    asleep <= 1'b1;
    settle;
    `CHK("wake", 1'b1, wake)
    asleep <= 1'b0;
    bus(1'b0, EVT_ADDR, 32'h0);
    `CHK("events", 32'h3, rd)
    issue(1'b1, 3'h1, VEC_S1);
    src1_n <= 1'b1;
    settle;
    issue(1'b0, 3'h0, 12'h0);
    leave(FPIU_NORMAL, 1'b1);
    issue(1'b1, 3'h3, VEC_S3);
    evt <= 8'h02;
    bus(1'b1, EVT_ADDR, 32'h1);
    leave(FPIU_NORMAL, 1'b1);
    issue(1'b1, 3'h4, VEC_S4);
    evt <= 8'h00;
    bus(1'b1, EVT_ADDR, 32'hFF);
    leave(FPIU_NORMAL, 1'b0);
    issue(1'b0, 3'h0, 12'h0);
  endtask
  // edge latches collapse, falling edge on source one, nmi preempts
  task automatic t_edge;
    bus(1'b1, OPT_ADDR, 32'h30);
    src2 <= 1'b1;
    settle;
    src2 <= 1'b0;
    settle;
    src2 <= 1'b1;
    settle;
    issue(1'b1, 3'h2, VEC_S2);
    leave(FPIU_NORMAL, 1'b1);
    issue(1'b0, 3'h0, 12'h0);
    src2 <= 1'b0;
    settle;
    bus(1'b1, OPT_ADDR, 32'h10);
    src1_n <= 1'b0;
    settle;
    src1_n <= 1'b1;
    settle;
    issue(1'b1, 3'h1, VEC_S1);
    nmi_n <= 1'b0;
    settle;
    issue(1'b1, 3'h0, VEC_NMI);
    nmi_n <= 1'b1;
    leave(FPIU_SERVICE, 1'b0);
    leave(FPIU_NORMAL, 1'b0);
  endtask
  // clock
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  // reset then scenarios
  initial begin
    i_rst = 1'b1;
    {hsel, hwrite, src2, go, back, asleep} = '0;
    {nmi_n, src1_n} = 2'h3;
    {clr_load, flags_we, flags_wr} = '0;
    {haddr, evt, htrans, hsize, hwdata} = '0;
    err_total = 0;
    samples_checked = 0;
    repeat (5) @(posedge i_mclk);
    i_rst <= 1'b0;
    @(posedge i_mclk);
    t_reset;
    t_gen_off;
    t_priority;
    t_edge;
    t_flags;
    report_and_stop;
  end
endmodule
